// [lcdid_pkg.sv]
`default_nettype none
package lcdid_pkg;
  // clock and internal oscillator
  localparam int      CLK_HZ       = 200_000_000;
  localparam int      OSC_HZ       = 540_000;
  localparam int      OSC_DIV      = CLK_HZ / OSC_HZ;
  // execution times in ns, and in oscillator ticks rounded up
  localparam longint  EXEC_SHORT_NS = 18_500;
  localparam longint  EXEC_LONG_NS  = 760_000;
  localparam int      EXEC_SHORT_TICKS = int'((EXEC_SHORT_NS * OSC_HZ + 999_999_999) / 1_000_000_000);
  localparam int      EXEC_LONG_TICKS  = int'((EXEC_LONG_NS * OSC_HZ + 999_999_999) / 1_000_000_000);
  // cursor blink interval in ms, in oscillator ticks
  localparam int      BLINK_MS     = 185;
  localparam int      BLINK_TICKS  = BLINK_MS * (OSC_HZ / 1000);
  // panel and memory geometry
  localparam int      SEG_N        = 40;
  localparam int      COM_N        = 16;
  localparam int      COM_1L       = 8;
  localparam int      DOTS         = 5;
  localparam int      ROWS         = 8;
  localparam int      ROM_CHARS    = 256;
  localparam int      ROM_BITS     = ROM_CHARS * ROWS * DOTS;
  localparam int      TEXT_DEPTH   = 128;
  localparam int      GLYPH_DEPTH  = 64;
  // display text ram addressing
  localparam logic [7:0] SPACE_CODE   = 8'h20;
  localparam logic [6:0] HOME_ADDR    = 7'h00;
  localparam logic [6:0] LINE2_BASE   = 7'h40;
  localparam logic [6:0] LINE1_LAST   = 7'h27;
  localparam logic [6:0] LINE2_LAST   = 7'h67;
  localparam logic [6:0] ONE_LAST     = 7'h4F;
  localparam logic [6:0] LINE_LEN     = 7'h28;
  localparam logic [6:0] ONE_LINE_LEN = 7'h50;
  localparam int         BUSY_BIT     = 7;
  // host register map and fields
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_STAT     = 8'h04;
  localparam logic [7:0] REG_CFG      = 8'h08;
  localparam int         CMD_RS_BIT   = 8;
  localparam int         CMD_RD_BIT   = 9;
  localparam int         CFG_FOUR_BIT = 0;
  localparam int         CFG_POLL_BIT = 1;
  localparam logic       RST_POLL     = 1'b1;
  localparam logic [1:0] SETUP_CYCLES = 2'h2;
  // host sequencer states
  typedef enum logic [1:0] {H_IDLE, H_SET, H_WAIT, H_STB} lcdid_hst_t;
endpackage : lcdid_pkg
`default_nettype wire

// [lcdid_link_if.sv]
`default_nettype none
interface lcdid_link_if;
  logic       register_select; // high: data ram, low: instruction / status
  logic       read_sel;        // high: read, low: write
  logic       strobe;          // one-cycle transfer strobe from the host
  logic [7:0] host_db_o;
  logic       host_db_oe;
  logic [7:0] dev_db_o;
  logic       dev_db_oe;
  logic [7:0] db;
  // wire level of the data bus, pulled high when nobody drives
  assign db = host_db_oe ? host_db_o : (dev_db_oe ? dev_db_o : 8'hFF);
  modport host (output register_select, read_sel, strobe, host_db_o, host_db_oe, input db);
  modport dev  (input register_select, read_sel, strobe, db, output dev_db_o, dev_db_oe);
endinterface : lcdid_link_if
`default_nettype wire

// [lcdid_device.sv]
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`default_nettype none
// Functional notes
// - 16 commons two-line, 8 one-line, 40 segments
// - dots shift serially, then latch 40 segments
// - fixed ROM: 256 glyphs of 5x8 dots
// - eight writable user glyphs shown like built-ins
// - code bits 2..0 give glyph address 5..3
// - row eight ORs cursor; host keeps it clear
// - byte bits 4..0 are dots, bit 4 left
// - user glyph when code bits 7..4 zero
// - dot bit one lights, zero stays dark
// - data read returns ram byte at counter
// - data write stores byte at counter
// - clear: spaces, counter zero, increment, long busy
// - home: counter zero, unshift, long busy
// - entry mode sets direction and auto shift
// - display, cursor, blink on/off bits
// - shift display or cursor, right or left
// - function set: width, lines, font
// - load user glyph address into counter
// - load text address into counter
// - status read: busy bit 7, counter below
// - counter steps after every ram access
// - four-bit width: two nibble transfers
// - host waits while busy before instructions
module lcdid_device #(
  parameter int                                   LONG_TICKS  = lcdid_pkg::EXEC_LONG_TICKS,
  parameter int                                   SHORT_TICKS = lcdid_pkg::EXEC_SHORT_TICKS,
  parameter int                                   BLINK_TICKS = lcdid_pkg::BLINK_TICKS,
  parameter int                                   OSC_DIV     = lcdid_pkg::OSC_DIV,
  parameter logic [lcdid_pkg::ROM_BITS-1:0]       GLYPH_ROM   = '0
) (
  // clock and reset
  input  wire logic                               hclk,
  input  wire logic                               hresetn,
  // host link
  lcdid_link_if.dev                               link,
  // panel drive
  output logic [lcdid_pkg::COM_N-1:0]             com,
  output logic [lcdid_pkg::SEG_N-1:0]             seg
);
  typedef struct packed {
    logic [lcdid_pkg::TEXT_DEPTH-1:0][7:0]  text;
    logic [lcdid_pkg::GLYPH_DEPTH-1:0][7:0] glyph;
    logic [6:0]                             ac;
    logic                                   cg_sel;
    logic                                   inc;
    logic                                   ent_shift;
    logic                                   disp;
    logic                                   cur;
    logic                                   blink;
    logic                                   eight;
    logic                                   two;
    logic                                   font;
    logic [6:0]                             shift;
    logic                                   busy;
    logic [15:0]                            busy_cnt;
    logic [15:0]                            osc_cnt;
    logic [16:0]                            blink_cnt;
    logic                                   blink_ph;
    logic [7:0]                             dr;
    logic                                   fetch;
    logic                                   nib;
    logic [3:0]                             hold;
    logic [7:0]                             db_o;
    logic                                   db_oe;
    logic [2:0]                             ch;
    logic [2:0]                             dot;
    logic [3:0]                             row;
    logic [lcdid_pkg::SEG_N-1:0]            chain;
    logic [lcdid_pkg::SEG_N-1:0]            seg;
    logic [lcdid_pkg::COM_N-1:0]            com;
  } lcdid_dev_st_t;

  lcdid_dev_st_t st_r;
  lcdid_dev_st_t st_nxt;

  // next counter address, wrapping at the end of each text line
  function automatic logic [6:0] lcdid_ac_step(input logic [6:0] a, input logic up,
                                               input logic cg, input logic two);
    logic [6:0] r;
    r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (cg) begin
      r = {1'b0, r[5:0]};
    end else if (two) begin
      if (up && a == lcdid_pkg::LINE1_LAST) r = lcdid_pkg::LINE2_BASE;
      else if (up && a == lcdid_pkg::LINE2_LAST) r = lcdid_pkg::HOME_ADDR;
      else if (!up && a == lcdid_pkg::HOME_ADDR) r = lcdid_pkg::LINE2_LAST;
      else if (!up && a == lcdid_pkg::LINE2_BASE) r = lcdid_pkg::LINE1_LAST;
    end else begin
      if (up && a == lcdid_pkg::ONE_LAST) r = lcdid_pkg::HOME_ADDR;
      else if (!up && a == lcdid_pkg::HOME_ADDR) r = lcdid_pkg::ONE_LAST;
    end
    return r;
  endfunction : lcdid_ac_step

  // next display shift offset, modulo the line length
  function automatic logic [6:0] lcdid_sh_step(input logic [6:0] s, input logic up,
                                               input logic two);
    logic [6:0] len;
    len = two ? lcdid_pkg::LINE_LEN : lcdid_pkg::ONE_LINE_LEN;
    if (up) return (7'(s + 7'h01) == len) ? 7'h00 : 7'(s + 7'h01);
    return (s == 7'h00) ? 7'(len - 7'h01) : 7'(s - 7'h01);
  endfunction : lcdid_sh_step

  // all next-state logic
  always_comb begin
    logic       tick;
    logic       done;
    logic [7:0] b;
    logic [7:0] rb;
    logic [6:0] pos;
    logic [6:0] addr;
    logic [7:0] code;
    logic [4:0] pat;
    logic       here;
    int         idx;
    tick = 1'b0;
    done = 1'b0;
    b    = 8'h00;
    rb   = 8'h00;
    idx  = 0;
    pos  = 7'h00;
    addr = 7'h00;
    code = 8'h00;
    pat  = 5'h00;
    here = 1'b0;
    st_nxt = st_r;
    // internal oscillator enable and blink phase
    if (st_r.osc_cnt == 16'(OSC_DIV - 1)) begin
      st_nxt.osc_cnt = 16'h0000;
      tick = 1'b1;
    end else begin
      st_nxt.osc_cnt = 16'(st_r.osc_cnt + 16'h0001);
    end
    if (tick) begin
      if (st_r.blink_cnt == 17'(BLINK_TICKS - 1)) begin
        st_nxt.blink_cnt = '0;
        st_nxt.blink_ph  = ~st_r.blink_ph;
      end else begin
        st_nxt.blink_cnt = 17'(st_r.blink_cnt + 17'h0_0001);
      end
      if (st_r.busy_cnt != 16'h0000) begin
        st_nxt.busy_cnt = 16'(st_r.busy_cnt - 16'h0001);
        st_nxt.busy     = (st_r.busy_cnt != 16'h0001);
      end
    end
    // scan: fetch one dot per cycle from text, glyph ram or rom
    pos = 7'(st_r.shift + {4'h0, st_r.ch});
    if (pos >= (st_r.two ? lcdid_pkg::LINE_LEN : lcdid_pkg::ONE_LINE_LEN)) begin
      pos = 7'(pos - (st_r.two ? lcdid_pkg::LINE_LEN : lcdid_pkg::ONE_LINE_LEN));
    end
    addr = (st_r.two && st_r.row[3]) ? 7'(pos + lcdid_pkg::LINE2_BASE) : pos;
    code = st_r.text[addr];
    if (code[7:4] == 4'h0) begin
      pat = st_r.glyph[{code[2:0], st_r.row[2:0]}][4:0];
    end else begin
      idx = int'({code, st_r.row[2:0]}) * lcdid_pkg::DOTS;
      pat = GLYPH_ROM[idx +: lcdid_pkg::DOTS];
    end
    here = (addr == st_r.ac) && !st_r.cg_sel;
    if (st_r.cur && here && st_r.row[2:0] == 3'h7) pat = pat | 5'h1F;
    if (st_r.blink && here && st_r.blink_ph) pat = 5'h1F;
    st_nxt.chain = {st_r.chain[lcdid_pkg::SEG_N-2:0], st_r.disp & pat[st_r.dot]};
    if (st_r.dot == 3'h0) begin
      st_nxt.dot = 3'h4;
      if (st_r.ch == 3'h7) begin
        st_nxt.ch  = 3'h0;
        st_nxt.seg = st_nxt.chain;
        st_nxt.com = '0;
        st_nxt.com[st_r.row] = 1'b1;
        if (st_r.row == (st_r.two ? 4'hF : 4'(lcdid_pkg::COM_1L - 1))) st_nxt.row = 4'h0;
        else st_nxt.row = 4'(st_r.row + 4'h1);
      end else begin
        st_nxt.ch = 3'(st_r.ch + 3'h1);
      end
    end else begin
      st_nxt.dot = 3'(st_r.dot - 3'h1);
    end
    // read buffer refill after address load or ram access
    if (st_r.fetch) begin
      st_nxt.dr    = st_r.cg_sel ? st_r.glyph[st_r.ac[5:0]] : st_r.text[st_r.ac];
      st_nxt.fetch = 1'b0;
    end
    // strobe: gather one byte, two nibbles in four-bit width
    if (link.strobe) begin
      if (!st_r.eight && !st_r.nib) begin
        st_nxt.nib  = 1'b1;
        st_nxt.hold = link.db[7:4];
      end else begin
        st_nxt.nib = 1'b0;
        done = 1'b1;
        b = st_r.eight ? link.db : {st_r.hold, link.db[7:4]};
      end
    end
    if (done && link.register_select) begin
      if (!link.read_sel) begin
        if (st_r.cg_sel) st_nxt.glyph[st_r.ac[5:0]] = b;
        else st_nxt.text[st_r.ac] = b;
        if (!st_r.cg_sel && st_r.ent_shift) begin
          st_nxt.shift = lcdid_sh_step(st_r.shift, st_r.inc, st_r.two);
        end
      end
      st_nxt.ac       = lcdid_ac_step(st_r.ac, st_r.inc, st_r.cg_sel, st_r.two);
      st_nxt.fetch    = 1'b1;
      st_nxt.busy     = 1'b1;
      st_nxt.busy_cnt = 16'(SHORT_TICKS);
    end else if (done && !link.read_sel) begin
      // instruction decode by leading one
      st_nxt.busy     = 1'b1;
      st_nxt.busy_cnt = 16'(SHORT_TICKS);
      casez (b)
        8'b1???_????: begin
          st_nxt.ac     = b[6:0];
          st_nxt.cg_sel = 1'b0;
          st_nxt.fetch  = 1'b1;
        end
        8'b01??_????: begin
          st_nxt.ac     = {1'b0, b[5:0]};
          st_nxt.cg_sel = 1'b1;
          st_nxt.fetch  = 1'b1;
        end
        8'b001?_????: begin
          st_nxt.eight = b[4];
          st_nxt.two   = b[3];
          st_nxt.font  = b[2];
        end
        8'b0001_????: begin
          if (b[3]) begin
            st_nxt.shift = lcdid_sh_step(st_r.shift, !b[2], st_r.two);
          end else begin
            st_nxt.ac    = lcdid_ac_step(st_r.ac, b[2], st_r.cg_sel, st_r.two);
            st_nxt.fetch = 1'b1;
          end
        end
        8'b0000_1???: begin
          st_nxt.disp  = b[2];
          st_nxt.cur   = b[1];
          st_nxt.blink = b[0];
        end
        8'b0000_01??: begin
          st_nxt.inc       = b[1];
          st_nxt.ent_shift = b[0];
        end
        8'b0000_001?: begin
          st_nxt.ac       = lcdid_pkg::HOME_ADDR;
          st_nxt.cg_sel   = 1'b0;
          st_nxt.shift    = 7'h00;
          st_nxt.fetch    = 1'b1;
          st_nxt.busy_cnt = 16'(LONG_TICKS);
        end
        8'b0000_0001: begin
          for (int i = 0; i < lcdid_pkg::TEXT_DEPTH; i++) begin
            st_nxt.text[i] = lcdid_pkg::SPACE_CODE;
          end
          st_nxt.ac       = lcdid_pkg::HOME_ADDR;
          st_nxt.cg_sel   = 1'b0;
          st_nxt.shift    = 7'h00;
          st_nxt.inc      = 1'b1;
          st_nxt.fetch    = 1'b1;
          st_nxt.busy_cnt = 16'(LONG_TICKS);
        end
        default: begin
          st_nxt.busy     = st_r.busy;
          st_nxt.busy_cnt = st_r.busy_cnt;
        end
      endcase
    end
    // read path: status or read buffer, high nibble first in four-bit width
    rb = link.register_select ? st_nxt.dr : {st_nxt.busy, st_nxt.ac};
    if (st_nxt.eight) st_nxt.db_o = rb;
    else st_nxt.db_o = st_nxt.nib ? {rb[3:0], 4'h0} : {rb[7:4], 4'h0};
    st_nxt.db_oe = link.read_sel;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r       <= '0;
      st_r.eight <= 1'b1;
      st_r.inc   <= 1'b1;
      st_r.dot   <= 3'h4;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign link.dev_db_o  = st_r.db_o;
  assign link.dev_db_oe = st_r.db_oe;
  assign com            = st_r.com;
  assign seg            = st_r.seg;
endmodule : lcdid_device
`default_nettype wire

// [lcdid_host.sv]
`default_nettype none
module lcdid_host (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // display link
  lcdid_link_if.host       link
);
  typedef struct packed {
    lcdid_pkg::lcdid_hst_t st;
    logic                  act;
    logic                  poll;
    logic                  nib;
    logic                  rs;
    logic                  rd;
    logic [7:0]            byte_w;
    logic [7:0]            rdata;
    logic [1:0]            cnt;
    logic                  four;
    logic                  apoll;
    logic                  wr_pend;
    logic [7:0]            wr_addr;
    logic                  rs_o;
    logic                  rw_o;
    logic                  stb;
    logic [7:0]            db_o;
    logic                  db_oe;
    logic [31:0]           hrdata;
  } lcdid_host_st_t;

  lcdid_host_st_t st_r;
  lcdid_host_st_t st_nxt;

  // bus slave and link sequencer
  always_comb begin
    logic [7:0] v;
    v = 8'h00;
    st_nxt = st_r;
    // data phase of a write taken in the previous cycle
    if (st_r.wr_pend) begin
      if (st_r.wr_addr == lcdid_pkg::REG_CMD && !st_r.act) begin
        st_nxt.act    = 1'b1;
        st_nxt.byte_w = hwdata[7:0];
        st_nxt.rs     = hwdata[lcdid_pkg::CMD_RS_BIT];
        st_nxt.rd     = hwdata[lcdid_pkg::CMD_RD_BIT];
        st_nxt.poll   = st_r.apoll;
        st_nxt.nib    = 1'b0;
        st_nxt.st     = lcdid_pkg::H_SET;
      end else if (st_r.wr_addr == lcdid_pkg::REG_CFG) begin
        st_nxt.four  = hwdata[lcdid_pkg::CFG_FOUR_BIT];
        st_nxt.apoll = hwdata[lcdid_pkg::CFG_POLL_BIT];
      end
    end
    // address phase, read data prepared for the following data phase
    st_nxt.wr_pend = hsel && hready && htrans[1] && hwrite;
    if (hsel && hready && htrans[1]) begin
      st_nxt.wr_addr = haddr[7:0];
      case (haddr[7:0])
        lcdid_pkg::REG_CMD:  st_nxt.hrdata = {22'h00_0000, st_r.rd, st_r.rs, st_r.byte_w};
        lcdid_pkg::REG_STAT: st_nxt.hrdata = {16'h0000, st_r.rdata, 7'h00, st_r.act};
        lcdid_pkg::REG_CFG:  st_nxt.hrdata = {30'h0000_0000, st_r.apoll, st_r.four};
        default:             st_nxt.hrdata = 32'h0000_0000;
      endcase
    end
    // link sequencer: set select lines, wait, strobe, sample
    st_nxt.stb = 1'b0;
    case (st_r.st)
      lcdid_pkg::H_IDLE: begin
        st_nxt.db_oe = 1'b0;
        st_nxt.rw_o  = 1'b1;
      end
      lcdid_pkg::H_SET: begin
        st_nxt.rs_o  = st_r.poll ? 1'b0 : st_r.rs;
        st_nxt.rw_o  = st_r.poll ? 1'b1 : st_r.rd;
        st_nxt.db_oe = 1'b0;
        if (!st_r.four) st_nxt.db_o = st_r.byte_w;
        else st_nxt.db_o = st_r.nib ? {st_r.byte_w[3:0], 4'h0} : {st_r.byte_w[7:4], 4'h0};
        st_nxt.cnt = 2'h0;
        st_nxt.st  = lcdid_pkg::H_WAIT;
      end
      lcdid_pkg::H_WAIT: begin
        st_nxt.db_oe = !st_r.rw_o;
        st_nxt.cnt   = 2'(st_r.cnt + 2'h1);
        if (2'(st_r.cnt + 2'h1) == lcdid_pkg::SETUP_CYCLES) begin
          st_nxt.stb = 1'b1;
          st_nxt.st  = lcdid_pkg::H_STB;
        end
      end
      lcdid_pkg::H_STB: begin
        v = st_r.four ? {st_r.rdata[7:4], link.db[7:4]} : link.db;
        if (st_r.four && !st_r.nib) begin
          st_nxt.nib        = 1'b1;
          st_nxt.rdata[7:4] = link.db[7:4];
          st_nxt.st         = lcdid_pkg::H_SET;
        end else if (st_r.poll) begin
          st_nxt.nib  = 1'b0;
          st_nxt.poll = v[lcdid_pkg::BUSY_BIT];
          st_nxt.st   = lcdid_pkg::H_SET;
        end else begin
          st_nxt.nib = 1'b0;
          if (st_r.rd) st_nxt.rdata = v;
          st_nxt.act = 1'b0;
          st_nxt.st  = lcdid_pkg::H_IDLE;
        end
      end
      default: st_nxt.st = lcdid_pkg::H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r       <= '0;
      st_r.st    <= lcdid_pkg::H_IDLE;
      st_r.apoll <= lcdid_pkg::RST_POLL;
      st_r.rw_o  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register; zero wait, always okay
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign hrdata               = st_r.hrdata;
  assign link.register_select = st_r.rs_o;
  assign link.read_sel        = st_r.rw_o;
  assign link.strobe          = st_r.stb;
  assign link.host_db_o       = st_r.db_o;
  assign link.host_db_oe      = st_r.db_oe;
endmodule : lcdid_host
`default_nettype wire

// [lcdid_monitor.sv]
`default_nettype none
module lcdid_monitor (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // link signals
  input wire logic       register_select,
  input wire logic       read_sel,
  input wire logic       strobe,
  input wire logic [7:0] host_db_o,
  input wire logic       host_db_oe,
  input wire logic [7:0] dev_db_o,
  input wire logic       dev_db_oe,
  input wire logic [7:0] db
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // one write or read transfer on the link
  sequence s_wr;
    strobe && !read_sel;
  endsequence
  sequence s_rd;
    strobe && read_sel;
  endsequence
  // spacing, qualifiers and data bus ownership around each strobe
  chk_strobe_spacing: assert property (strobe |=> !strobe [*3])
    else $error("strobes closer than four cycles");
  chk_sel_stable: assert property (strobe |-> $stable(register_select) && $stable(read_sel))
    else $error("select lines moved at the strobe");
  chk_write_drive: assert property (s_wr |-> host_db_oe && db == host_db_o)
    else $error("write strobe without host data");
  chk_read_drive: assert property (s_rd |-> dev_db_oe && !host_db_oe && db == dev_db_o)
    else $error("read strobe without device data");
  chk_oe_setup: assert property ($rose(host_db_oe) |-> !strobe ##1 s_wr)
    else $error("host drive not one cycle ahead of strobe");
  chk_oe_release: assert property (s_wr |=> host_db_oe ##1 !host_db_oe)
    else $error("host drive not released after strobe");
  chk_dev_follow: assert property ($past(hresetn) |-> dev_db_oe == $past(read_sel))
    else $error("device drive does not follow read select");
  chk_no_clash: assert property (!(host_db_oe && dev_db_oe))
    else $error("both ends drive the data bus");
endmodule : lcdid_monitor
`default_nettype wire

// [char_lcd_instruction_decoder_bench.sv]
`default_nettype none
module char_lcd_instruction_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] com;
  logic [39:0] seg;
  int          failures = 0;
  int          cmp_count = 0;
  // both ends joined over the link
  lcdid_link_if link ();
  lcdid_host u_lcdid_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link(link));
  lcdid_device #(.LONG_TICKS(4), .SHORT_TICKS(2), .BLINK_TICKS(8), .OSC_DIV(4)) u_lcdid_device (
    .hclk(hclk), .hresetn(hresetn), .link(link), .com(com), .seg(seg));
  lcdid_monitor u_lcdid_monitor (.hclk(hclk), .hresetn(hresetn),
    .register_select(link.register_select), .read_sel(link.read_sel), .strobe(link.strobe),
    .host_db_o(link.host_db_o), .host_db_oe(link.host_db_oe), .dev_db_o(link.dev_db_o),
    .dev_db_oe(link.dev_db_oe), .db(link.db));
  // 200 MHz clock
  initial forever #2.5 hclk = ~hclk;
  // verdict and end of run
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tmo;
    failures++;
    $display("wrong value at %0t: wait ran out", $time);
    end_sim;
  endtask : tmo
  // one single ahb-lite word transfer
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) tmo;
  endtask : xfer
  // one link transfer, polled until the host sequencer is idle
  task lcd(input logic rs, input logic rd, input logic [7:0] b, output logic [7:0] r);
    logic [31:0] t;
    int          n;
    xfer(1'b1, lcdid_pkg::REG_CMD, {22'h00_0000, rd, rs, b}, t);
    xfer(1'b0, lcdid_pkg::REG_STAT, '0, t);
    for (n = 0; n < 200 && t[0] !== 1'b0; n++) xfer(1'b0, lcdid_pkg::REG_STAT, '0, t);
    if (n >= 200) tmo;
    r = t[15:8];
  endtask : lcd
  task ins(input logic [7:0] b);
    logic [7:0] r;
    lcd(1'b0, 1'b0, b, r);
  endtask : ins
  task wr(input logic [7:0] b);
    logic [7:0] r;
    lcd(1'b1, 1'b0, b, r);
  endtask : wr
  // expectations: status byte once idle, and lit dots of a glyph row
  function automatic logic [7:0] stat(input logic [6:0] ac);
    return {1'b0, ac};
  endfunction : stat
  function automatic logic [4:0] row_dots(input logic [7:0] b);
    return b[4:0];
  endfunction : row_dots
  task st_chk(input logic [6:0] ac);
    logic [7:0] r;
    lcd(1'b0, 1'b1, 8'h00, r);
    check({hresp, r}, {1'b0, stat(ac)});
  endtask : st_chk
  task rd_chk(input logic [7:0] e);
    logic [7:0] r;
    lcd(1'b1, 1'b1, 8'h00, r);
    check(r, e);
  endtask : rd_chk
  // panel watch: glyph on char 0, upper commons, stray dots elsewhere
  task watch(output logic g, output logic hi, output logic st);
    g = 1'b0;
    hi = 1'b0;
    st = 1'b0;
    repeat (1500) begin
      @(negedge hclk);
      if (seg[39:35] === row_dots(8'hF5)) g = 1'b1;
      if (com[15:8] !== 8'h00) hi = 1'b1;
      if (seg[34:0] !== '0) st = 1'b1;
    end
  endtask : watch
  // main sequence
  initial begin
    logic [7:0]  d [8];
    logic [31:0] t;
    logic [6:0]  a;
    logic        g, hi, st;
    int          i;
    i = $urandom(59);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, lcdid_pkg::REG_STAT, '0, t);
    check(t, '0);
    a = 7'($urandom_range(31));
    ins({1'b1, a});
    for (i = 0; i < 8; i++) begin
      d[i] = 8'($urandom);
      wr(d[i]);
    end
    st_chk(a + 7'h08);
    ins({1'b1, a});
    for (i = 0; i < 8; i++) rd_chk(d[i]);
    ins(8'h04);
    wr(8'h55);
    st_chk(a + 7'h07);
    ins(8'h14);
    ins(8'h18);
    st_chk(a + 7'h08);
    ins(8'h03);
    st_chk(7'h00);
    ins({1'b1, a});
    rd_chk(d[0]);
    ins(8'h01);
    st_chk(7'h00);
    wr(8'h20);
    st_chk(7'h01);
    ins(8'hA7);
    rd_chk(lcdid_pkg::SPACE_CODE);
    // user glyph 0: seven lit rows with junk upper bits, dark row 7
    ins(8'h40);
    for (i = 0; i < 8; i++) wr(i < 7 ? 8'hF5 : 8'h00);
    st_chk(7'h08);
    ins(8'h80);
    wr(8'h08);
    ins(8'h0C);
    watch(g, hi, st);
    check(g, 1'b1);
    check(hi, 1'b0);
    check(st, 1'b0);
    ins(8'h38);
    watch(g, hi, st);
    check(hi, 1'b1);
    // switch to four-bit transfers and repeat a readback
    ins(8'h20);
    xfer(1'b1, lcdid_pkg::REG_CFG, 32'h0000_0003, t);
    ins(8'h28);
    ins({1'b1, a});
    // text was cleared to spaces since, and cell 0 now holds the user glyph code
    rd_chk((a == 7'h00) ? 8'h08 : lcdid_pkg::SPACE_CODE);
    st_chk(a + 7'h01);
    end_sim;
  end
endmodule : char_lcd_instruction_decoder_bench
`default_nettype wire
